// File: rtl/bia_pkg.sv
// shared constants for the interrupt request and acknowledge link
package bia_pkg;
  timeunit 1ns;
  timeprecision 1ns;
  // clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int ADDR_SETUP_NS = 35;
  localparam int ADDR_SETUP_RAW = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_SETUP_CYC = (ADDR_SETUP_RAW < 1) ? 1 : ADDR_SETUP_RAW;
  localparam int CNT_W = 4;

  // widths
  localparam int NUM_LVL = 7;
  localparam int LVL_W = 3;
  localparam int ID_W = 8;

  // levels and reset values
  localparam logic [LVL_W-1:0] LVL_NONE = 3'h0;
  localparam logic [ID_W-1:0] ID_RST = 8'h00;
  localparam logic [NUM_LVL:1] IRQ_IDLE = 7'h7F;
  localparam logic PIN_HI = 1'b1;
  localparam logic PIN_LO = 1'b0;
endpackage : bia_pkg

// File: rtl/bia_if.sv
// bus wires between interrupt handler and interrupter, with pull-up resolution
interface bia_if;
  timeunit 1ns;
  timeprecision 1ns;
  // handler drive values and one common enable for its master lines
  logic                                h_as_n;
  logic                                h_ds0_n;
  logic                                h_ds1_n;
  logic                                h_write_n;
  logic                                h_iack_n;
  logic [bia_pkg::LVL_W-1:0]           h_addr;
  logic                                h_oe;
  // interrupter drive values and enables
  logic [bia_pkg::NUM_LVL:1]           d_irq_oe;
  logic [bia_pkg::ID_W-1:0]            d_data;
  logic                                d_data_oe;
  logic                                d_dtack_oe;
  logic                                d_iackout_n;
  // resolved wire levels, undriven lines float high
  logic [bia_pkg::NUM_LVL:1]           irq_n;
  logic                                as_n;
  logic                                ds0_n;
  logic                                ds1_n;
  logic                                write_n;
  logic                                iack_n;
  logic                                iackin_n;
  logic [bia_pkg::LVL_W:1]             addr;
  logic [bia_pkg::ID_W-1:0]            data;
  logic                                dtack_n;

  assign irq_n    = ~d_irq_oe;
  assign as_n     = h_oe ? h_as_n : bia_pkg::PIN_HI;
  assign ds0_n    = h_oe ? h_ds0_n : bia_pkg::PIN_HI;
  assign ds1_n    = h_oe ? h_ds1_n : bia_pkg::PIN_HI;
  assign write_n  = h_oe ? h_write_n : bia_pkg::PIN_HI;
  assign iack_n   = h_oe ? h_iack_n : bia_pkg::PIN_HI;
  // acknowledge line feeds the first slot's daisy input
  assign iackin_n = iack_n;
  assign addr     = h_oe ? h_addr : {bia_pkg::LVL_W{bia_pkg::PIN_HI}};
  assign data     = d_data_oe ? d_data : {bia_pkg::ID_W{bia_pkg::PIN_HI}};
  assign dtack_n  = ~d_dtack_oe;

  modport handler (
    output h_as_n, h_ds0_n, h_ds1_n, h_write_n, h_iack_n, h_addr, h_oe,
    input  irq_n, dtack_n, data
  );
  modport interrupter (
    output d_irq_oe, d_data, d_data_oe, d_dtack_oe, d_iackout_n,
    input  as_n, ds0_n, iack_n, iackin_n, addr
  );
endinterface : bia_if

// File: rtl/bia_interrupter.sv
// interrupter end: raises one request level, answers its acknowledge or passes the daisy chain
module bia_interrupter #(
  parameter int LEVEL = 4
) (
  // clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      clk_en_i,
  // user side
  input  wire logic                      raise_i,
  input  wire logic [bia_pkg::ID_W-1:0]  status_id_i,
  output logic                           pending_o,
  output logic                           acked_o,
  output logic                           slave_ok_o,
  // bus side
  bia_if.interrupter                     bus
);
  timeunit 1ns;
  timeprecision 1ns;
  typedef enum logic [2:0] {BIA_D_IDLE, BIA_D_PASS, BIA_D_DATA, BIA_D_ACK, BIA_D_DONE} bia_dst_e;

  generate
    if (LEVEL < 1 || LEVEL > bia_pkg::NUM_LVL) begin : g_bad_level
      $error("interrupter level out of range");
    end
  endgenerate

  localparam logic [bia_pkg::LVL_W-1:0] MY_LVL = bia_pkg::LVL_W'(LEVEL);
  localparam int SW = 4 + bia_pkg::LVL_W;

  // two-stage synchronisers for all bus inputs
  logic [SW-1:0]                sync1_ff;
  logic [SW-1:0]                sync2_ff;
  logic                         as_s;
  logic                         ds0_s;
  logic                         iack_s;
  logic                         iackin_s;
  logic [bia_pkg::LVL_W-1:0]    addr_s;
  logic                         match;
  logic                         clearing;

  bia_dst_e                     state_ff;
  bia_dst_e                     nxt_state;
  logic                         pend_ff;
  logic                         nxt_pend;
  logic [bia_pkg::ID_W-1:0]     id_ff;
  logic [bia_pkg::ID_W-1:0]     nxt_id;
  logic                         dat_oe_ff;
  logic                         nxt_dat_oe;
  logic                         dtk_oe_ff;
  logic                         nxt_dtk_oe;
  logic                         iackout_ff;
  logic                         nxt_iackout;
  logic                         acked_ff;
  logic                         nxt_acked;
  logic                         slave_ok_ff;
  logic                         nxt_slave_ok;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_ff <= {SW{bia_pkg::PIN_HI}};
      sync2_ff <= {SW{bia_pkg::PIN_HI}};
    end else if (clk_en_i) begin
      sync1_ff <= {bus.as_n, bus.ds0_n, bus.iack_n, bus.iackin_n, bus.addr};
      sync2_ff <= sync1_ff;
    end
  end

  // address modifier and upper address lines are never looked at
  assign {as_s, ds0_s, iack_s, iackin_s, addr_s} = sync2_ff;
  assign match    = pend_ff && (addr_s == MY_LVL);
  assign clearing = (state_ff == BIA_D_ACK) && ds0_s;

  always_comb begin
    nxt_state    = state_ff;
    nxt_pend     = pend_ff;
    nxt_id       = id_ff;
    nxt_dat_oe   = dat_oe_ff;
    nxt_dtk_oe   = dtk_oe_ff;
    nxt_iackout  = iackout_ff;
    nxt_acked    = 1'b0;
    // ordinary slave logic may work only while the acknowledge line is high
    nxt_slave_ok = iack_s && (state_ff == BIA_D_IDLE);
    unique case (state_ff)
      BIA_D_IDLE: begin
        nxt_iackout = bia_pkg::PIN_HI;
        // address strobe confirmed before the level code is judged
        if (!iackin_s && !as_s && !iack_s) begin
          if (match) begin
            nxt_state  = BIA_D_DATA;
            nxt_dat_oe = 1'b1;
          end else begin
            nxt_state   = BIA_D_PASS;
            nxt_iackout = bia_pkg::PIN_LO;
          end
        end
      end
      BIA_D_PASS: begin
        // decision held until the daisy input rises, so no stray pulse downstream
        if (iackin_s) begin
          nxt_state   = BIA_D_IDLE;
          nxt_iackout = bia_pkg::PIN_HI;
        end
      end
      BIA_D_DATA: begin
        if (iack_s) begin
          nxt_state  = BIA_D_IDLE;
          nxt_dat_oe = 1'b0;
        end else if (!ds0_s) begin
          nxt_state  = BIA_D_ACK;
          nxt_dtk_oe = 1'b1;
        end
      end
      BIA_D_ACK: begin
        if (ds0_s) begin
          nxt_state  = BIA_D_DONE;
          nxt_dat_oe = 1'b0;
          nxt_dtk_oe = 1'b0;
          nxt_pend   = 1'b0;
          nxt_acked  = 1'b1;
        end
      end
      BIA_D_DONE: begin
        if (iackin_s) begin
          nxt_state = BIA_D_IDLE;
        end
      end
    endcase
    // a new raise in the clearing cycle wins
    if (raise_i && (!pend_ff || clearing)) begin
      nxt_pend = 1'b1;
      nxt_id   = status_id_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff    <= BIA_D_IDLE;
      pend_ff     <= 1'b0;
      id_ff       <= bia_pkg::ID_RST;
      dat_oe_ff   <= 1'b0;
      dtk_oe_ff   <= 1'b0;
      iackout_ff  <= bia_pkg::PIN_HI;
      acked_ff    <= 1'b0;
      slave_ok_ff <= 1'b0;
    end else if (clk_en_i) begin
      state_ff    <= nxt_state;
      pend_ff     <= nxt_pend;
      id_ff       <= nxt_id;
      dat_oe_ff   <= nxt_dat_oe;
      dtk_oe_ff   <= nxt_dtk_oe;
      iackout_ff  <= nxt_iackout;
      acked_ff    <= nxt_acked;
      slave_ok_ff <= nxt_slave_ok;
    end
  end

  // request line pulled low only on the assigned level
  always_comb begin
    for (int i = 1; i <= bia_pkg::NUM_LVL; i++) begin
      bus.d_irq_oe[i] = pend_ff && (i == LEVEL);
    end
  end
  assign bus.d_data      = id_ff;
  assign bus.d_data_oe   = dat_oe_ff;
  assign bus.d_dtack_oe  = dtk_oe_ff;
  assign bus.d_iackout_n = iackout_ff;
  assign pending_o       = pend_ff;
  assign acked_o         = acked_ff;
  assign slave_ok_o      = slave_ok_ff;
endmodule : bia_interrupter

// File: rtl/bia_handler.sv
// interrupt handler end: ranks requests, wins the bus, runs the acknowledge read
module bia_handler #(
  parameter int LVL_LO = 1,
  parameter int LVL_HI = 7
) (
  // clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       nrst_i,
  input  wire logic                       clk_en_i,
  // on-board bus requester
  output logic                            bus_req_o,
  input  wire logic                       bus_grant_i,
  // servicing side
  output logic                            busy_o,
  output logic                            svc_start_o,
  output logic [bia_pkg::LVL_W-1:0]       svc_level_o,
  output logic [bia_pkg::ID_W-1:0]        svc_id_o,
  // bus side
  bia_if.handler                          bus
);
  timeunit 1ns;
  timeprecision 1ns;
  typedef enum logic [2:0] {BIA_H_IDLE, BIA_H_REQ, BIA_H_SETUP, BIA_H_STRB, BIA_H_WAIT, BIA_H_END} bia_hst_e;

  // a range is two bounds, so a gapped set cannot be expressed
  generate
    if (LVL_LO < 1 || LVL_HI > bia_pkg::NUM_LVL || LVL_LO > LVL_HI) begin : g_bad_range
      $error("handler level range is not a contiguous run within 1..7");
    end
  endgenerate

  localparam int SW = bia_pkg::NUM_LVL + 1 + bia_pkg::ID_W;
  localparam logic [bia_pkg::CNT_W-1:0] SETUP_LOAD = bia_pkg::CNT_W'(bia_pkg::ADDR_SETUP_CYC);

  // highest pending level within range, zero when none
  function automatic logic [bia_pkg::LVL_W-1:0] pick_level(input logic [bia_pkg::NUM_LVL:1] req_n);
    logic [bia_pkg::LVL_W-1:0] lvl;
    lvl = bia_pkg::LVL_NONE;
    for (int i = LVL_LO; i <= LVL_HI; i++) begin
      if (!req_n[i]) begin
        lvl = bia_pkg::LVL_W'(i);
      end
    end
    return lvl;
  endfunction : pick_level

  // two-stage synchronisers for request lines, data acknowledge and data
  logic [SW-1:0]                  sync1_ff;
  logic [SW-1:0]                  sync2_ff;
  logic [bia_pkg::NUM_LVL:1]      irq_s;
  logic                           dtack_s;
  logic [bia_pkg::ID_W-1:0]       data_s;
  logic [bia_pkg::LVL_W-1:0]      top_lvl;
  logic                           any_req;

  bia_hst_e                       state_ff;
  bia_hst_e                       nxt_state;
  logic [bia_pkg::CNT_W-1:0]      cnt_ff;
  logic [bia_pkg::CNT_W-1:0]      nxt_cnt;
  logic                           req_ff;
  logic                           nxt_req;
  logic                           oe_ff;
  logic                           nxt_oe;
  logic                           as_ff;
  logic                           nxt_as;
  logic                           ds0_ff;
  logic                           nxt_ds0;
  logic                           iack_ff;
  logic                           nxt_iack;
  logic [bia_pkg::LVL_W-1:0]      lvl_ff;
  logic [bia_pkg::LVL_W-1:0]      nxt_lvl;
  logic [bia_pkg::ID_W-1:0]       id_ff;
  logic [bia_pkg::ID_W-1:0]       nxt_id;
  logic                           start_ff;
  logic                           nxt_start;
  logic                           busy_ff;
  logic                           nxt_busy;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_ff <= {SW{bia_pkg::PIN_HI}};
      sync2_ff <= {SW{bia_pkg::PIN_HI}};
    end else if (clk_en_i) begin
      sync1_ff <= {bus.irq_n, bus.dtack_n, bus.data};
      sync2_ff <= sync1_ff;
    end
  end

  assign {irq_s, dtack_s, data_s} = sync2_ff;
  assign top_lvl = pick_level(irq_s);
  assign any_req = (top_lvl != bia_pkg::LVL_NONE);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_req   = req_ff;
    nxt_oe    = oe_ff;
    nxt_as    = as_ff;
    nxt_ds0   = ds0_ff;
    nxt_iack  = iack_ff;
    nxt_lvl   = lvl_ff;
    nxt_id    = id_ff;
    nxt_start = 1'b0;
    nxt_busy  = busy_ff;
    unique case (state_ff)
      BIA_H_IDLE: begin
        if (any_req) begin
          // the requester must win the bus before any acknowledge
          nxt_req   = 1'b1;
          nxt_busy  = 1'b1;
          nxt_state = BIA_H_REQ;
        end
      end
      BIA_H_REQ: begin
        if (bus_grant_i) begin
          if (any_req) begin
            // level re-ranked at grant: a higher one may have arrived meanwhile
            nxt_lvl   = top_lvl;
            nxt_oe    = 1'b1;
            nxt_iack  = bia_pkg::PIN_LO;
            nxt_cnt   = SETUP_LOAD;
            nxt_state = BIA_H_SETUP;
          end else begin
            nxt_req   = 1'b0;
            nxt_busy  = 1'b0;
            nxt_state = BIA_H_IDLE;
          end
        end
      end
      BIA_H_SETUP: begin
        if (cnt_ff > 1) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_as    = bia_pkg::PIN_LO;
          nxt_state = BIA_H_STRB;
        end
      end
      BIA_H_STRB: begin
        nxt_ds0   = bia_pkg::PIN_LO;
        nxt_state = BIA_H_WAIT;
      end
      BIA_H_WAIT: begin
        // no timeout: an answering interrupter is assumed on the level
        if (!dtack_s) begin
          nxt_id    = data_s;
          nxt_as    = bia_pkg::PIN_HI;
          nxt_ds0   = bia_pkg::PIN_HI;
          nxt_state = BIA_H_END;
        end
      end
      BIA_H_END: begin
        if (dtack_s) begin
          nxt_oe    = 1'b0;
          nxt_iack  = bia_pkg::PIN_HI;
          nxt_req   = 1'b0;
          nxt_busy  = 1'b0;
          nxt_start = 1'b1;
          nxt_state = BIA_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= BIA_H_IDLE;
      cnt_ff   <= '0;
      req_ff   <= 1'b0;
      oe_ff    <= 1'b0;
      as_ff    <= bia_pkg::PIN_HI;
      ds0_ff   <= bia_pkg::PIN_HI;
      iack_ff  <= bia_pkg::PIN_HI;
      lvl_ff   <= bia_pkg::LVL_NONE;
      id_ff    <= bia_pkg::ID_RST;
      start_ff <= 1'b0;
      busy_ff  <= 1'b0;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      req_ff   <= nxt_req;
      oe_ff    <= nxt_oe;
      as_ff    <= nxt_as;
      ds0_ff   <= nxt_ds0;
      iack_ff  <= nxt_iack;
      lvl_ff   <= nxt_lvl;
      id_ff    <= nxt_id;
      start_ff <= nxt_start;
      busy_ff  <= nxt_busy;
    end
  end

  // bus pins: only three address lines exist on this end, data is input only
  assign bus.h_oe      = oe_ff;
  assign bus.h_addr    = lvl_ff;
  assign bus.h_as_n    = as_ff;
  assign bus.h_ds0_n   = ds0_ff;
  assign bus.h_ds1_n   = bia_pkg::PIN_HI;
  assign bus.h_write_n = bia_pkg::PIN_HI;
  assign bus.h_iack_n  = iack_ff;

  // servicing side
  assign bus_req_o   = req_ff;
  assign busy_o      = busy_ff;
  assign svc_start_o = start_ff;
  assign svc_level_o = lvl_ff;
  assign svc_id_o    = id_ff;
endmodule : bia_handler

// File: tb/bia_link_sva.sv
// concurrent checks on the acknowledge link between handler and interrupter
module bia_link_sva #(
  parameter int LEVEL = 5
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       nrst_i,
  input  wire logic [bia_pkg::NUM_LVL:1]  irq_n,
  input  wire logic                       as_n,
  input  wire logic                       ds0_n,
  input  wire logic                       ds1_n,
  input  wire logic                       write_n,
  input  wire logic                       iack_n,
  input  wire logic                       iackin_n,
  input  wire logic [bia_pkg::LVL_W:1]    addr,
  input  wire logic                       dtack_n,
  input  wire logic                       d_data_oe,
  input  wire logic                       d_dtack_oe,
  input  wire logic                       d_iackout_n,
  // second link, daisy side only
  input  wire logic                       b_data_oe,
  input  wire logic                       b_dtack_oe,
  input  wire logic                       b_iackout_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  a_byte_read_only: assert property (!ds0_n |-> ds1_n && write_n && !iack_n)
    else $error("strobe or write level wrong in acknowledge");
  a_iack_whole_access: assert property (!as_n |-> !iack_n)
    else $error("address strobe low without acknowledge line low");
  a_own_line_only: assert property (&(irq_n | (7'h01 << (LEVEL - 1))))
    else $error("request on a foreign level");
  a_answer_needs_match: assert property ($rose(d_data_oe) |-> !as_n && !iackin_n && !irq_n[LEVEL])
    else $error("byte driven without a matching acknowledge");
  a_dtack_level_code: assert property (!dtack_n |-> d_data_oe && addr == 3'(LEVEL))
    else $error("data acknowledge without byte or with wrong level code");
  a_byte_before_ack: assert property ($rose(d_dtack_oe) |-> !ds0_n && $past(d_data_oe))
    else $error("data acknowledge before byte or strobe");
  a_release_on_strobe: assert property ($rose(ds0_n) && !iack_n |->
    ##[1:4] (!d_dtack_oe && !d_data_oe && irq_n[LEVEL]))
    else $error("byte, acknowledge or request not released after strobe");
  a_pass_or_answer: assert property (!d_iackout_n |-> !d_data_oe && !d_dtack_oe)
    else $error("daisy passed while answering");
  // the first link always matches, so passing is only ever seen on the second
  a_second_pass_clean: assert property (!b_iackout_n |-> !b_data_oe && !b_dtack_oe)
    else $error("second link passed the chain while answering");
endmodule : bia_link_sva

// File: tb/bia_link_tb.sv
// bench: handler and interrupter joined, plus a bench-driven second interrupter
module bia_link_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_i;
  logic        nrst_i;
  logic        clk_en_i;
  logic        raise;
  logic        raise_b;
  logic [7:0]  sid;
  logic        grant;
  logic        bus_req;
  logic        busy;
  logic        svc_start;
  logic [2:0]  svc_level;
  logic [7:0]  svc_id;
  logic        pending;
  logic        pending_b;
  logic        acked;
  logic        slave_ok;
  int          err_total;
  int          compares;
  logic        grant_h;
  logic        bus_req_h;
  logic        svc_start_h;
  logic [2:0]  svc_level_h;
  logic [7:0]  svc_id_h;
  bia_if bus ();
  bia_if bus_b ();
  bia_if bus_h ();

  bia_handler u_bia_handler (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
    .bus_req_o(bus_req), .bus_grant_i(grant), .busy_o(busy), .svc_start_o(svc_start),
    .svc_level_o(svc_level), .svc_id_o(svc_id), .bus(bus.handler));
  bia_interrupter #(.LEVEL(5)) u_bia_interrupter (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .clk_en_i(clk_en_i), .raise_i(raise), .status_id_i(sid), .pending_o(pending),
    .acked_o(acked), .slave_ok_o(slave_ok), .bus(bus.interrupter));
  // second end faces the bench so that wrong levels can be offered
  bia_interrupter #(.LEVEL(4)) u_bia_interrupter_2 (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .clk_en_i(clk_en_i), .raise_i(raise_b), .status_id_i(sid), .pending_o(pending_b),
    .acked_o(), .slave_ok_o(), .bus(bus_b.interrupter));
  // third link: the bench plays interrupters on several levels against a narrowed range
  bia_handler #(.LVL_LO(2), .LVL_HI(6)) u_bia_handler_2 (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .clk_en_i(clk_en_i), .bus_req_o(bus_req_h), .bus_grant_i(grant_h), .busy_o(),
    .svc_start_o(svc_start_h), .svc_level_o(svc_level_h), .svc_id_o(svc_id_h), .bus(bus_h.handler));
  bia_link_sva #(.LEVEL(5)) u_bia_link_sva (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .irq_n(bus.irq_n), .as_n(bus.as_n), .ds0_n(bus.ds0_n), .ds1_n(bus.ds1_n),
    .write_n(bus.write_n), .iack_n(bus.iack_n), .iackin_n(bus.iackin_n), .addr(bus.addr),
    .dtack_n(bus.dtack_n), .d_data_oe(bus.d_data_oe), .d_dtack_oe(bus.d_dtack_oe),
    .d_iackout_n(bus.d_iackout_n), .b_data_oe(bus_b.d_data_oe), .b_dtack_oe(bus_b.d_dtack_oe),
    .b_iackout_n(bus_b.d_iackout_n));

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic report_and_stop;
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // offer an acknowledge on the second link, then let the sync flops settle
  task automatic offer(input logic [2:0] lvl, input logic ack_n, input logic strobe_n);
    bus_b.h_addr   = lvl;
    bus_b.h_iack_n = ack_n;
    bus_b.h_as_n   = ack_n;
    bus_b.h_ds0_n  = strobe_n;
    repeat (5) @(negedge sys_clk_i);
  endtask : offer

  // bounded wait on the third link: 0 address strobe, 1 data strobe 0, 2 service start
  task automatic wait_h(input int sel, input logic val);
    int n;
    n = 0;
    while (((sel == 0) ? bus_h.as_n : (sel == 1) ? bus_h.ds0_n : svc_start_h) !== val) begin
      @(negedge sys_clk_i);
      n++;
      if (n > 200) begin
        err_total++;
        report_and_stop();
      end
    end
  endtask : wait_h

  task automatic run_ack(input logic [7:0] id, input int gdelay);
    logic ack_seen;
    logic slave_low;
    int   n;
    ack_seen  = 1'b0;
    slave_low = 1'b0;
    sid   = id;
    raise = 1'b1;
    @(negedge sys_clk_i);
    raise = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    check(bus.irq_n[5], 1'b0);
    check(bus_req, 1'b1);
    check(busy, 1'b1);
    repeat (gdelay) @(negedge sys_clk_i);
    check(bus.iack_n, 1'b1);
    grant = 1'b1;
    n = 0;
    while (svc_start !== 1'b1) begin
      @(negedge sys_clk_i);
      if (acked === 1'b1) ack_seen = 1'b1;
      if (slave_ok === 1'b0) slave_low = 1'b1;
      n++;
      if (n > 200) begin
        err_total++;
        report_and_stop();
      end
    end
    grant = 1'b0;
    check(busy, 1'b0);
    check(svc_level, 3'h5);
    check(svc_id, id);
    check(ack_seen, 1'b1);
    check(slave_low, 1'b1);
    check(pending, 1'b0);
    @(negedge sys_clk_i);
    check(svc_start, 1'b0);
    check(bus.iack_n, 1'b1);
    check(bus.irq_n, 7'h7F);
  endtask : run_ack

  initial begin
    err_total = 0;
    compares  = 0;
    nrst_i    = 1'b0;
    clk_en_i  = 1'b1;
    raise     = 1'b0;
    raise_b   = 1'b0;
    sid       = 8'h00;
    grant     = 1'b0;
    bus_b.h_oe      = 1'b1;
    bus_b.h_ds1_n   = 1'b1;
    bus_b.h_write_n = 1'b1;
    bus_b.h_addr    = 3'h0;
    bus_b.h_iack_n  = 1'b1;
    bus_b.h_as_n    = 1'b1;
    bus_b.h_ds0_n   = 1'b1;
    grant_h           = 1'b0;
    bus_h.d_irq_oe    = 7'h00;
    bus_h.d_data      = 8'h00;
    bus_h.d_data_oe   = 1'b0;
    bus_h.d_dtack_oe  = 1'b0;
    bus_h.d_iackout_n = 1'b1;
    repeat (12) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    @(negedge sys_clk_i);
    check(bus_req, 1'b0);
    check(bus.irq_n, 7'h7F);
    run_ack(8'hA5, 6);
    run_ack(8'h3C, 0);
    // nothing pending: the chain must be passed on
    offer(3'h4, 1'b0, 1'b1);
    check(bus_b.d_iackout_n, 1'b0);
    offer(3'h4, 1'b1, 1'b1);
    check(bus_b.d_iackout_n, 1'b1);
    sid     = 8'hC3;
    raise_b = 1'b1;
    @(negedge sys_clk_i);
    raise_b = 1'b0;
    offer(3'h3, 1'b0, 1'b1);
    check(bus_b.d_iackout_n, 1'b0);
    check(bus_b.d_data_oe, 1'b0);
    offer(3'h3, 1'b1, 1'b1);
    offer(3'h4, 1'b0, 1'b1);
    check(bus_b.data, 8'hC3);
    check(bus_b.dtack_n, 1'b1);
    check(bus_b.d_iackout_n, 1'b1);
    // enable low freezes the answer although the strobe is offered
    clk_en_i = 1'b0;
    offer(3'h4, 1'b0, 1'b0);
    check(bus_b.dtack_n, 1'b1);
    clk_en_i = 1'b1;
    offer(3'h4, 1'b0, 1'b0);
    check(bus_b.dtack_n, 1'b0);
    offer(3'h4, 1'b0, 1'b1);
    check(bus_b.dtack_n, 1'b1);
    check(bus_b.d_data_oe, 1'b0);
    check(pending_b, 1'b0);
    check(bus_b.irq_n, 7'h7F);
    offer(3'h4, 1'b1, 1'b1);
    // third link: levels 3, 6 and 7 at once, the handler serves 2..6 only
    bus_h.d_data   = 8'h96;
    bus_h.d_irq_oe = 7'h64;
    repeat (4) @(negedge sys_clk_i);
    check(bus_req_h, 1'b1);
    check(bus_h.iack_n, 1'b1);
    grant_h = 1'b1;
    wait_h(0, 1'b0);
    grant_h = 1'b0;
    check(bus_h.iack_n, 1'b0);
    check(bus_h.addr, 3'h6);
    bus_h.d_data_oe = 1'b1;
    wait_h(1, 1'b0);
    check(bus_h.write_n, 1'b1);
    check(bus_h.ds1_n, 1'b1);
    bus_h.d_dtack_oe = 1'b1;
    wait_h(1, 1'b1);
    check(svc_id_h, 8'h96);
    bus_h.d_data_oe  = 1'b0;
    bus_h.d_dtack_oe = 1'b0;
    bus_h.d_irq_oe   = 7'h00;
    wait_h(2, 1'b1);
    check(svc_level_h, 3'h6);
    check(bus_h.iack_n, 1'b1);
    check(bus_req_h, 1'b0);
    report_and_stop();
  end
endmodule : bia_link_tb
